// ---- design/pcp_pkg.sv ----
/*
  Constants and types for the port configuration register bank and the
  power pushbuttons of a four-port power-sourcing controller.
  Assumes the serial slave front end turns host transactions into one-cycle
  register write and read strobes with an 8-bit register address.
*/
// Behaviour
// RULE1: enable register: class bits 7:4, detect bits 3:0
// RULE2: backoff enables bits 3:0, bits 7:4 read zero
// RULE3: timing register packs restart, startup, fault, disconnect codes
// RULE4: restart code gives 16, 32, 64, zero fault multiples
// RULE5: disconnect and startup/fault codes scale nominal times
// RULE6: restart off time enforces minimum duty cycle
// RULE7: reset clears timing register to zero
// RULE8: class-limit bit lowers fault threshold by class
// RULE9: misc bit7 interrupt enable, bit6 restart protection
// RULE10: bit3 blocks power-on after class failure, automatic
// RULE11: reset loads misc register with c0
// RULE12: pushbuttons: bits 7:4 power off, 3:0 power on
// RULE13: ignore power-on when powered or shutdown
// RULE14: ignore power-off when off or shutdown
// RULE15: pushbutton bits self-clear after the action
// RULE16: power-on aborts detection or classification first
// RULE17: pushbuttons ignored for power-on in automatic mode
// RULE18: reset clears pushbutton register
// RULE19: modes: shutdown, manual, semi-automatic, automatic
// RULE20: detection runs before classification when both enabled
// RULE21: no repower until restart timer reaches zero
// RULE22: reserved bits read zero, writes ignored
package pcp_pkg;
  localparam int unsigned PORTS = 4;
  localparam logic [7:0] ADDR_DET_CLS = 8'h14;
  localparam logic [7:0] ADDR_BACKOFF = 8'h15;
  localparam logic [7:0] ADDR_TIMING = 8'h16;
  localparam logic [7:0] ADDR_MISC = 8'h17;
  localparam logic [7:0] ADDR_PUSH = 8'h19;
  localparam logic [7:0] RST_TIMING = 8'h00;
  localparam logic [7:0] RST_MISC = 8'hc0;
  localparam logic [7:0] RST_PUSH = 8'h00;
  // reserved bits 5:4 and 1:0 hold zero whatever is written
  localparam logic [7:0] MISC_WMASK = 8'hcc;
  localparam logic [3:0] BACKOFF_WMASK = 4'hf;
  localparam int unsigned MISC_INT_EN_BIT = 7;
  localparam int unsigned MISC_RESTART_BIT = 6;
  localparam int unsigned MISC_CLASS_FAIL_BIT = 3;
  localparam int unsigned MISC_CLASS_LIMIT_BIT = 2;
  // multiples of the fault time, zero for code 11
  localparam logic [6:0] RESTART_MULT_00 = 7'h10;
  localparam logic [6:0] RESTART_MULT_01 = 7'h20;
  localparam logic [6:0] RESTART_MULT_10 = 7'h40;
  localparam logic [6:0] RESTART_MULT_11 = 7'h00;
  localparam int unsigned NOMINAL_DISC_MS = 350;
  localparam int unsigned NOMINAL_START_MS = 60;
  localparam int unsigned NOMINAL_FAULT_MS = 60;
  // scale in quarters of nominal
  localparam logic [3:0] QTR_1 = 4'h1;
  localparam logic [3:0] QTR_2 = 4'h2;
  localparam logic [3:0] QTR_4 = 4'h4;
  localparam logic [3:0] QTR_8 = 4'h8;
  localparam logic [3:0] QTR_16 = 4'h0 - 4'h0;

  typedef enum logic [1:0] {
    PCP_MODE_SHUTDOWN = 2'b00,
    PCP_MODE_MANUAL = 2'b01,
    PCP_MODE_SEMI = 2'b10,
    PCP_MODE_AUTO = 2'b11
  } pcp_mode_t;

  typedef struct packed {
    logic [1:0] restart_multiple_code;
    logic [1:0] startup_time_code;
    logic [1:0] fault_time_code;
    logic [1:0] disconnect_time_code;
  } pcp_timing_t;

  typedef struct packed {
    logic [1:0] disconnect_scale;
    logic [2:0] startup_scale;
    logic [2:0] fault_scale;
    logic [6:0] restart_mult;
  } pcp_timer_cfg_t;

  typedef struct packed {
    logic [3:0] powered;
    logic [3:0] busy;
    logic [3:0] class_fail;
    logic [3:0] overcurrent_off;
    logic [3:0] restart_zero;
  } pcp_port_stat_t;
endpackage

// ---- design/pcp_regs.sv ----
/*
  Configuration register bank: detect/classify enables, cadence backoff,
  timer codes, protection options and self-clearing power pushbuttons.
  Assumes reg_wr/reg_rd are one-cycle strobes from the serial slave and
  port state comes synchronously from the per-port state machines.
*/
module pcp_regs
  import pcp_pkg::*;
#(
  parameter logic [7:0] DET_CLS_RESET = 8'hff,
  parameter logic [3:0] BACKOFF_RESET = 4'h0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic [7:0] port_mode,
  input wire pcp_port_stat_t port_stat,
  input wire logic [3:0] port_done,
  output logic [3:0] detect_enable_bit,
  output logic [3:0] class_enable_bit,
  output logic [3:0] detect_first,
  output logic [3:0] cadence_backoff_bit,
  output pcp_timing_t timer_codes,
  output pcp_timer_cfg_t timer_cfg,
  output logic int_enable,
  output logic restart_protect_enable,
  output logic block_power_on_class_fail,
  output logic class_limit_scaling_enable,
  output logic [3:0] fault_limit_scaled,
  output logic [3:0] power_up_request,
  output logic [3:0] power_down_request,
  output logic [3:0] abort_discovery,
  output logic [3:0] power_on_allowed
);
  logic [7:0] det_cls_q;
  logic [3:0] backoff_q;
  pcp_timing_t timing_q;
  logic [7:0] misc_q;
  logic [3:0] on_q;
  logic [3:0] off_q;
  logic [7:0] rdata_q;
  logic [3:0] on_ok;
  logic [3:0] off_ok;
  logic wr_push;

  assign wr_push = reg_wr && (reg_addr == ADDR_PUSH);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      det_cls_q <= DET_CLS_RESET;
      backoff_q <= BACKOFF_RESET;
    end
    else if (soft_rst)
    begin
      det_cls_q <= DET_CLS_RESET;
      backoff_q <= BACKOFF_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_DET_CLS)
        det_cls_q <= reg_wdata; // RULE1
      if (reg_addr == ADDR_BACKOFF)
        backoff_q <= reg_wdata[3:0] & BACKOFF_WMASK; // RULE2 RULE22
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      timing_q <= RST_TIMING; // RULE7
    else if (soft_rst)
      timing_q <= RST_TIMING; // RULE7
    else if (reg_wr && reg_addr == ADDR_TIMING)
      timing_q <= reg_wdata; // RULE3
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      misc_q <= RST_MISC; // RULE11
    else if (soft_rst)
      misc_q <= RST_MISC; // RULE11
    else if (reg_wr && reg_addr == ADDR_MISC)
      misc_q <= reg_wdata & MISC_WMASK; // RULE9 RULE22
  end

  // a port counts as able to act only outside shutdown
  always_comb
  begin
    for (int p = 0; p < PORTS; p++)
    begin
      on_ok[p] = (port_mode[2*p +: 2] == PCP_MODE_MANUAL || port_mode[2*p +: 2] == PCP_MODE_SEMI) // RULE17 RULE19
        && !port_stat.powered[p] && power_on_allowed[p]; // RULE13
      off_ok[p] = (port_mode[2*p +: 2] != PCP_MODE_SHUTDOWN) && port_stat.powered[p]; // RULE14
      power_on_allowed[p] = !(restart_protect_enable && port_stat.overcurrent_off[p]
        && !port_stat.restart_zero[p]) // RULE6 RULE21
        && !(block_power_on_class_fail && port_stat.class_fail[p]
        && port_mode[2*p +: 2] == PCP_MODE_AUTO); // RULE10
    end
  end

  // ignored requests drop at once, accepted ones stand until done;
  // a new write wins over the clear so no request is lost
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      on_q <= RST_PUSH[3:0]; // RULE18
      off_q <= RST_PUSH[7:4]; // RULE18
    end
    else if (soft_rst)
    begin
      on_q <= RST_PUSH[3:0];
      off_q <= RST_PUSH[7:4];
    end
    else
    begin
      for (int p = 0; p < PORTS; p++)
      begin
        if (wr_push && reg_wdata[p])
          on_q[p] <= 1'b1; // RULE12
        else if (port_done[p] || !on_ok[p])
          on_q[p] <= 1'b0; // RULE15 RULE13
        if (wr_push && reg_wdata[PORTS + p])
          off_q[p] <= 1'b1; // RULE12
        else if (port_done[p] || !off_ok[p])
          off_q[p] <= 1'b0; // RULE15 RULE14
      end
    end
  end

  assign power_up_request = on_q & on_ok;
  assign power_down_request = off_q & off_ok;
  assign abort_discovery = on_q & on_ok & port_stat.busy; // RULE16

  assign detect_enable_bit = det_cls_q[3:0];
  assign class_enable_bit = det_cls_q[7:4];
  assign detect_first = det_cls_q[3:0] & det_cls_q[7:4]; // RULE20
  assign cadence_backoff_bit = backoff_q;
  assign timer_codes = timing_q;
  assign int_enable = misc_q[MISC_INT_EN_BIT];
  assign restart_protect_enable = misc_q[MISC_RESTART_BIT];
  assign block_power_on_class_fail = misc_q[MISC_CLASS_FAIL_BIT];
  assign class_limit_scaling_enable = misc_q[MISC_CLASS_LIMIT_BIT];
  assign fault_limit_scaled = {PORTS{class_limit_scaling_enable}}; // RULE8

  always_comb
  begin
    unique case (timing_q.restart_multiple_code) // RULE4
      2'b00: timer_cfg.restart_mult = RESTART_MULT_00;
      2'b01: timer_cfg.restart_mult = RESTART_MULT_01;
      2'b10: timer_cfg.restart_mult = RESTART_MULT_10;
      2'b11: timer_cfg.restart_mult = RESTART_MULT_11;
    endcase
    // disconnect: 0=1x 1=1/4 2=1/2 3=2x; start/fault in halves of nominal: 0=1x 1=1/2 2=2x 3=scale 0
    timer_cfg.disconnect_scale = timing_q.disconnect_time_code; // RULE5
    unique case (timing_q.startup_time_code) // RULE5
      2'b00: timer_cfg.startup_scale = 3'd2;
      2'b01: timer_cfg.startup_scale = 3'd1;
      2'b10: timer_cfg.startup_scale = 3'd4;
      2'b11: timer_cfg.startup_scale = 3'd0;
    endcase
    unique case (timing_q.fault_time_code) // RULE5
      2'b00: timer_cfg.fault_scale = 3'd2;
      2'b01: timer_cfg.fault_scale = 3'd1;
      2'b10: timer_cfg.fault_scale = 3'd4;
      2'b11: timer_cfg.fault_scale = 3'd0;
    endcase
  end

  // pushbutton register is write-only and reads zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_DET_CLS: rdata_q <= det_cls_q;
        ADDR_BACKOFF: rdata_q <= {4'h0, backoff_q}; // RULE22
        ADDR_TIMING: rdata_q <= timing_q;
        ADDR_MISC: rdata_q <= misc_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_hit = (reg_addr == ADDR_DET_CLS) || (reg_addr == ADDR_BACKOFF) || (reg_addr == ADDR_TIMING)
    || (reg_addr == ADDR_MISC) || (reg_addr == ADDR_PUSH);
endmodule // pcp_regs

// ---- dv/pcp_regs_asserts.sv ----
/* checker on the register bank ports
   bound to pcp_regs from the testbench top */
module pcp_regs_asserts
  import pcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic [7:0] port_mode,
  input wire logic [3:0] port_done,
  input wire pcp_timing_t timer_codes,
  input wire logic int_enable,
  input wire logic [3:0] power_up_request
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence misc_wr_s;
    reg_wr && reg_addr == ADDR_MISC && !soft_rst;
  endsequence
  reset_value_a: assert property ($fell(rst) |-> int_enable && timer_codes == RST_TIMING)
    else $error("bad reset value");
  soft_reset_a: assert property (soft_rst |=> int_enable && timer_codes == RST_TIMING)
    else $error("bad soft reset value");
  addr_decode_a: assert property (reg_hit == (reg_addr inside {8'h14, 8'h15, 8'h16, 8'h17, 8'h19}))
    else $error("bad address decode");
  timing_write_a: assert property (reg_wr && reg_addr == ADDR_TIMING && !soft_rst |=> timer_codes == $past(reg_wdata))
    else $error("timing write lost");
  int_write_a: assert property (misc_wr_s |=> int_enable == $past(reg_wdata[7]))
    else $error("int enable write lost");
  zero_read_a: assert property (reg_rd && (!reg_hit || reg_addr == ADDR_PUSH) |=> reg_rdata == 8'h00)
    else $error("nonzero read");
  done_clear_a: assert property (port_done[0] && !reg_wr |=> !power_up_request[0])
    else $error("request not cleared");
  auto_ignore_a: assert property (port_mode[1:0] inside {2'b00, 2'b11} |-> !power_up_request[0])
    else $error("request in auto or shutdown");
endmodule // pcp_regs_asserts

// ---- dv/pcp_port_model.sv ----
/* port state machine model: powers ports on request
   assumes level requests held until done */
module pcp_port_model
  import pcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [15:0] other,
  input wire logic [3:0] up_req,
  input wire logic [3:0] dn_req,
  output pcp_port_stat_t stat,
  output logic [3:0] done
);
  logic [3:0] pwr_q;
  logic [2:0] cnt_q;
  assign stat = {pwr_q, other};
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pwr_q <= 4'h0;
      cnt_q <= 3'h0;
      done <= 4'h0;
    end
    else
    begin
      done <= 4'h0;
      cnt_q <= 3'h0;
      // guard on done: no second pulse before the request drops
      if ((up_req | dn_req) != 4'h0 && done == 4'h0)
        cnt_q <= cnt_q + 3'h1;
      if ((up_req | dn_req) != 4'h0 && done == 4'h0 && cnt_q >= {slow, 2'h0})
      begin
        done <= up_req | dn_req;
        pwr_q <= (pwr_q | up_req) & ~dn_req;
      end
    end
  end
endmodule // pcp_port_model

// ---- dv/pcp_port_config_and_power_buttons_test.sv ----
/* self-checking bench for pcp_regs
   drives the register strobes at the falling edge */
module pcp_port_config_and_power_buttons_test
  import pcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, soft_rst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0, rd_d = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, port_mode = 8'h55;
  logic [15:0] other = 16'h000f;
  logic [3:0] done, up_req, dn_req, abort;
  logic reg_hit, int_enable;
  pcp_port_stat_t stat;
  pcp_timing_t timer_codes;
  pcp_timer_cfg_t cfg;
  logic [7:0] exp_q[$];
  logic [7:0] mk[4] = '{8'hff, 8'h0f, 8'hff, 8'hcc};
  logic [7:0] rm[4] = '{8'h10, 8'h20, 8'h40, 8'h00};
  logic [7:0] sm[4] = '{8'h02, 8'h01, 8'h04, 8'h00};
  logic [31:0] seed = 32'h59a0d31f;
  int error_cnt = 0, compares = 0;
  pcp_regs u_dut (.clk, .rst, .soft_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .port_mode,
    .port_stat(stat), .port_done(done), .detect_enable_bit(), .class_enable_bit(), .detect_first(),
    .cadence_backoff_bit(), .timer_codes, .timer_cfg(cfg), .int_enable, .restart_protect_enable(),
    .block_power_on_class_fail(), .class_limit_scaling_enable(), .fault_limit_scaled(),
    .power_up_request(up_req), .power_down_request(dn_req), .abort_discovery(abort), .power_on_allowed());
  pcp_port_model u_port (.clk, .rst, .slow, .other, .up_req, .dn_req, .stat, .done);
  initial forever #12.5 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    error_cnt += int'(s !== e);
    if (s !== e)
      $display("[FAIL] %s expected %h seen %h", n, e, s);
  endtask
  // reads note the expected value; the monitor compares it
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    if (!w)
      exp_q.push_back(d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 20 && done === 4'h0; i++)
      @(negedge clk);
    @(negedge clk);
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk)
    if (rd_d)
      chk("reg_rdata", exp_q.pop_front(), reg_rdata);
  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    op(0, ADDR_MISC, RST_MISC);
    op(0, ADDR_TIMING, RST_TIMING);
    op(0, ADDR_PUSH, RST_PUSH);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      op(1, ADDR_DET_CLS + 8'(i % 4), seed[7:0]);
      op(0, ADDR_DET_CLS + 8'(i % 4), seed[7:0] & mk[i % 4]);
    end
    op(0, 8'h18, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      op(1, ADDR_TIMING, 8'(c * 8'h55));
      chk("restart_mult", rm[c], 8'(cfg.restart_mult));
      chk("startup_scale", sm[c], 8'(cfg.startup_scale));
      chk("fault_scale", sm[c], 8'(cfg.fault_scale));
      chk("disconnect_scale", 8'(c), 8'(cfg.disconnect_scale));
    end
    $display("register test done");
    op(1, ADDR_PUSH, 8'h01);
    wait_done();
    chk("powered", 8'(stat.powered), 8'h01);
    chk("up_req", 8'(up_req), 8'h00);
    op(1, ADDR_PUSH, 8'h01);
    chk("up_req", 8'(up_req), 8'h00);
    slow = 1'b1;
    op(1, ADDR_PUSH, 8'h10);
    chk("dn_req", 8'(dn_req), 8'h01);
    wait_done();
    chk("powered", 8'(stat.powered), 8'h00);
    op(1, ADDR_PUSH, 8'h10);
    chk("dn_req", 8'(dn_req), 8'h00);
    other = 16'h200f;
    op(1, ADDR_PUSH, 8'h02);
    chk("abort", 8'(abort), 8'h02);
    wait_done();
    other = 16'h000f;
    op(0, ADDR_PUSH, 8'h00);
    port_mode = 8'h57;
    op(1, ADDR_PUSH, 8'h01);
    chk("up_req", 8'(up_req), 8'h00);
    port_mode = 8'h54;
    op(1, ADDR_PUSH, 8'h01);
    chk("up_req", 8'(up_req), 8'h00);
    $display("pushbutton test done");
    soft_rst = 1'b1;
    @(negedge clk);
    soft_rst = 1'b0;
    op(0, ADDR_MISC, RST_MISC);
    op(0, ADDR_TIMING, RST_TIMING);
    $display("soft reset test done");
    end_sim();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule // pcp_port_config_and_power_buttons_test
bind pcp_regs pcp_regs_asserts u_chk (.clk, .rst, .soft_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .reg_hit, .port_mode, .port_done, .timer_codes, .int_enable, .power_up_request);
